// file: pkg/emps_pkg.sv
// Purpose: Constants and types for the external memory port selection block.
// Assumes: One system clock, synchronous active-high reset.
// Notes: Registers are reached as special-function registers by a plain SFR port.
//
// What this block does
// - Route memory interface to lower or, on large packages, upper port group.
// - With skip enable set, crossbar bypasses write, read and, if multiplexed, latch pins.
// - Interface owns its pins only while an off-chip external move executes.
// - After an access, pins return to port latches, or to crossbar on lower group.
// - During an access, drivers of pins acting as inputs are turned off.
// - Interface never changes pin output mode; output mode registers keep ruling.
// - Eight-bit indirect moves take the address high byte from the page register.
package emps_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] EMPS_PAGE_ADDR = 8'hA2;
  localparam logic [7:0] EMPS_CFG_ADDR = 8'hA3;
  localparam logic [7:0] EMPS_XBAR_CFG_ADDR = 8'hE3;
  localparam logic [7:0] EMPS_PAGE_RST = 8'h00;
  localparam logic [7:0] EMPS_CFG_RST = 8'h03;
  localparam logic [7:0] EMPS_XBAR_CFG_RST = 8'h00;
  localparam logic [7:0] EMPS_CFG_WMASK = 8'h3F;
  localparam int EMPS_BANK_SEL_BIT = 5;
  localparam int EMPS_NONMUX_BIT = 4;
  localparam int EMPS_SKIP_BIT = 1;
  // Pin positions of the strobes inside port 0 of the lower group.
  localparam int EMPS_WR_PIN = 7;
  localparam int EMPS_RD_PIN = 6;
  localparam int EMPS_ALE_PIN = 5;
  localparam int EMPS_NPORTS = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    EMPS_IDLE = 3'b001,
    EMPS_RUN = 3'b010,
    EMPS_DONE = 3'b100
  } emps_state_t;
endpackage : emps_pkg

// file: pkg/emps_pin_if.sv
// Purpose: Carries the interface's per-group pin drive between modules.
// Assumes: Four ports of eight pins per group.
// Notes: Mux module drives, top module samples.
interface emps_pin_if;
  logic [31:0] lo_out;
  logic [31:0] lo_oe;
  logic [31:0] hi_out;
  logic [31:0] hi_oe;
  logic [7:0] lo_skip;
  modport src (output lo_out, output lo_oe, output hi_out, output hi_oe, output lo_skip);
  modport dst (input lo_out, input lo_oe, input hi_out, input hi_oe, input lo_skip);
endinterface : emps_pin_if

// file: verilog/emps_pin_mux.sv
// Purpose: Combines port latches, crossbar and the memory interface per pin.
// Assumes: Owner signals are already registered in the top module.
// Notes: Purely combinational; output mode is never touched here.
module emps_pin_mux (
  input wire logic own,
  input wire logic upper,
  input wire logic skip_en,
  input wire logic nonmux,
  input wire logic [31:0] mem_out,
  input wire logic [31:0] mem_in_mask,
  input wire logic [31:0] latch_lo,
  input wire logic [31:0] latch_hi,
  input wire logic [31:0] xbar_out,
  input wire logic [31:0] xbar_oe,
  emps_pin_if.src pins
);
  import emps_pkg::*;

  // ****************************************
  // Pin selection
  // ****************************************
  // Owner of each pin group: memory interface during an access to that group, else default owner.
  always_comb begin
    pins.lo_skip = '0;
    if (skip_en) begin
      pins.lo_skip[EMPS_WR_PIN] = 1'b1;
      pins.lo_skip[EMPS_RD_PIN] = 1'b1;
      pins.lo_skip[EMPS_ALE_PIN] = ~nonmux;
    end
    pins.lo_out = xbar_out;
    pins.lo_oe = xbar_oe;
    pins.hi_out = latch_hi;
    pins.hi_oe = '1;
    if (own && !upper) begin
      pins.lo_out = mem_out;
      pins.lo_oe = ~mem_in_mask;
    end
    if (own && upper) begin
      pins.hi_out = mem_out;
      pins.hi_oe = ~mem_in_mask;
    end
    if (!own) begin
      // Lower pins the crossbar skips fall back to their port latches.
      pins.lo_out[7:0] = (xbar_out[7:0] & ~pins.lo_skip) | (latch_lo[7:0] & pins.lo_skip);
      pins.lo_oe[7:0] = xbar_oe[7:0] | pins.lo_skip;
    end
  end
endmodule : emps_pin_mux

// file: verilog/emps_top.sv
// Purpose: Port selection, pin ownership and page register of the memory interface.
// Assumes: The core flags an off-chip external move for its whole duration.
// Notes: Output mode registers pass straight through and are never altered.
module emps_top #(
  parameter bit HAS_UPPER = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic move_active,
  input wire logic move_read,
  input wire logic move_short,
  input wire logic [15:0] move_addr,
  input wire logic [7:0] move_wdata,
  output logic [15:0] mem_addr_q,
  input wire logic [31:0] latch_lo,
  input wire logic [31:0] latch_hi,
  input wire logic [31:0] xbar_out,
  input wire logic [31:0] xbar_oe,
  input wire logic [63:0] pin_output_mode_regs,
  output logic [63:0] pin_mode_q,
  output logic [31:0] lo_out_q,
  output logic [31:0] lo_oe_q,
  output logic [31:0] hi_out_q,
  output logic [31:0] hi_oe_q,
  output logic [7:0] lo_skip_q,
  output logic ext_busy_q
);
  import emps_pkg::*;

  logic [7:0] xram_page_q, xram_page_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] xbar_cfg_q, xbar_cfg_d;
  logic [7:0] rdata_d;
  emps_state_t state_q, state_d;
  logic [15:0] addr_d;
  logic [31:0] mem_out, mem_in_mask;
  logic upper;
  emps_pin_if pins ();

  // ****************************************
  // Register file
  // ****************************************
  // Writes update the page, configuration and crossbar registers; reads return them.
  always_comb begin
    xram_page_d = xram_page_q;
    cfg_d = cfg_q;
    xbar_cfg_d = xbar_cfg_q;
    rdata_d = sfr_rdata;
    if (sfr_wr) begin
      unique case (sfr_addr)
        EMPS_PAGE_ADDR: xram_page_d = sfr_wdata;
        EMPS_CFG_ADDR: cfg_d = sfr_wdata & EMPS_CFG_WMASK;
        EMPS_XBAR_CFG_ADDR: xbar_cfg_d = sfr_wdata;
        default: ;
      endcase
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        EMPS_PAGE_ADDR: rdata_d = xram_page_q;
        EMPS_CFG_ADDR: rdata_d = cfg_q;
        EMPS_XBAR_CFG_ADDR: rdata_d = xbar_cfg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      xram_page_q <= EMPS_PAGE_RST;
      cfg_q <= EMPS_CFG_RST;
      xbar_cfg_q <= EMPS_XBAR_CFG_RST;
      sfr_rdata <= 8'h00;
    end else begin
      xram_page_q <= xram_page_d;
      cfg_q <= cfg_d;
      xbar_cfg_q <= xbar_cfg_d;
      sfr_rdata <= rdata_d;
    end
  end

  // Upper group only exists on the larger package.
  assign upper = HAS_UPPER & cfg_q[EMPS_BANK_SEL_BIT];

  // ****************************************
  // Access sequencer
  // ****************************************
  // Tracks an off-chip move and builds its address.
  always_comb begin
    state_d = state_q;
    addr_d = mem_addr_q;
    unique case (state_q)
      EMPS_IDLE: if (move_active) begin
        state_d = EMPS_RUN;
      end
      EMPS_RUN: if (!move_active) begin
        state_d = EMPS_DONE;
      end
      EMPS_DONE: state_d = move_active ? EMPS_RUN : EMPS_IDLE;
      default: state_d = EMPS_IDLE;
    endcase
    if (move_active) begin
      addr_d = move_short ? {xram_page_q, move_addr[7:0]} : move_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= EMPS_IDLE;
      mem_addr_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      mem_addr_q <= addr_d;
    end
  end

  // Memory-side drive: data lines on the first port, address on the next two, last port held high.
  assign mem_out = {8'hFF, mem_addr_q, move_wdata};
  assign mem_in_mask = {24'h000000, {8{move_read}}};

  emps_pin_mux u_mux (
    .own(state_q == EMPS_RUN),
    .upper(upper),
    .skip_en(xbar_cfg_q[EMPS_SKIP_BIT]),
    .nonmux(cfg_q[EMPS_NONMUX_BIT]),
    .mem_out(mem_out),
    .mem_in_mask(mem_in_mask),
    .latch_lo(latch_lo),
    .latch_hi(latch_hi),
    .xbar_out(xbar_out),
    .xbar_oe(xbar_oe),
    .pins(pins.src)
  );

  // ****************************************
  // Registered pin outputs
  // ****************************************
  // Output mode is copied unchanged every cycle, access or not.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_mode_q <= '0;
      lo_out_q <= '0;
      lo_oe_q <= '0;
      hi_out_q <= '0;
      hi_oe_q <= '0;
      lo_skip_q <= '0;
      ext_busy_q <= 1'b0;
    end else begin
      pin_mode_q <= pin_output_mode_regs;
      lo_out_q <= pins.lo_out;
      lo_oe_q <= pins.lo_oe;
      hi_out_q <= pins.hi_out;
      hi_oe_q <= pins.hi_oe;
      lo_skip_q <= pins.lo_skip;
      ext_busy_q <= (state_q == EMPS_RUN);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Register reset values, write paths and read data hold.
  page_reset_a: assert property ($rose(!reset) |-> $past(xram_page_q) == EMPS_PAGE_RST)
    else $error("Page register not cleared by reset.");
  page_write_a: assert property (sfr_wr && sfr_addr == EMPS_PAGE_ADDR
    |=> xram_page_q == $past(sfr_wdata))
    else $error("Page register write lost.");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("Read data changed without a read.");
  bank_rst_a: assert property ($rose(!reset) |-> !$past(cfg_q[EMPS_BANK_SEL_BIT]))
    else $error("Bank select not reset to zero.");

  // Address formation for short moves.
  short_addr_a: assert property (move_active && move_short
    |=> mem_addr_q[15:8] == $past(xram_page_q))
    else $error("Short move high byte not from page register.");

  // Pin ownership: taken only during a move and handed back after it.
  own_release_a: assert property (!move_active ##1 !move_active |=> !ext_busy_q)
    else $error("Pins held without an external move.");
  idle_hand_a: assert property (state_q != EMPS_RUN && upper
    |=> hi_out_q == $past(latch_hi))
    else $error("Upper pins not handed to latches outside access.");
  end_return_a: assert property (state_q == EMPS_RUN && !move_active
    |=> ##1 !ext_busy_q)
    else $error("Pins not returned after access.");
  lo_return_a: assert property (state_q != EMPS_RUN || upper
    |=> lo_out_q[31:8] == $past(xbar_out[31:8]) && lo_oe_q[31:8] == $past(xbar_oe[31:8]))
    else $error("Lower pins not handed back to the crossbar.");

  // Group selection and driver control during an access.
  bank_pick_a: assert property (state_q == EMPS_RUN && !upper
    |=> hi_out_q == $past(latch_hi))
    else $error("Upper group driven while lower selected.");
  hi_addr_a: assert property (state_q == EMPS_RUN && upper
    |=> hi_out_q[23:8] == $past(mem_addr_q))
    else $error("Upper group does not carry the access address.");
  read_drv_off_a: assert property (state_q == EMPS_RUN && move_read && upper
    |=> hi_oe_q[7:0] == 8'h00)
    else $error("Data drivers active during read.");
  lo_read_off_a: assert property (state_q == EMPS_RUN && move_read && !upper
    |=> lo_oe_q[7:0] == 8'h00)
    else $error("Lower data drivers active during read.");
  mode_pass_a: assert property (1'b1 |=> pin_mode_q == $past(pin_output_mode_regs))
    else $error("Output mode altered.");

  // Crossbar skip mask on the strobe and latch pins.
  skip_pins_a: assert property (xbar_cfg_q[EMPS_SKIP_BIT] |=> lo_skip_q[7:6] == 2'b11)
    else $error("Strobe pins not skipped.");
  ale_skip_a: assert property (xbar_cfg_q[EMPS_SKIP_BIT]
    |=> lo_skip_q[EMPS_ALE_PIN] == !$past(cfg_q[EMPS_NONMUX_BIT]))
    else $error("Latch pin skip does not follow the multiplex mode.");

  // Main scenarios.
  lower_acc_c: cover property (state_q == EMPS_RUN && !upper);
  upper_acc_c: cover property (state_q == EMPS_RUN && upper && move_read);
  short_mv_c: cover property (move_active && move_short);
  lower_read_c: cover property (state_q == EMPS_RUN && !upper && move_read);
  skip_mux_c: cover property (xbar_cfg_q[EMPS_SKIP_BIT] && !cfg_q[EMPS_NONMUX_BIT]);
endmodule : emps_top

// file: test/emps_mem_model.sv
// Purpose: Behavioural off-chip memory watching one pin group.
// Assumes: Byte 0 is data and bytes 1-2 the address while the group is owned.
// Notes: Keeps the last write so the bench can compare it.
module emps_mem_model (
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_data_q = 8'h00;
  logic [15:0] last_addr_q = 16'h0000;
  // Latches a write only while the interface drives the data lines.
  always @(posedge sys_clk) begin
    if (busy && pin_oe[7:0] === 8'hFF) begin
      last_data_q <= pin_out[7:0];
      last_addr_q <= pin_out[23:8];
    end
  end
endmodule : emps_mem_model

// file: test/tb_emps_top.sv
// Purpose: Self-checking bench for the port selection block.
// Assumes: Inputs change at the falling edge of a 200 MHz clock.
// Notes: Lower port latches rest at one, upper at FFFF5AA5; output mode bit 15 is clear, the rest set.
module tb_emps_top;
  timeunit 1ns;
  timeprecision 1ps;
  import emps_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic move_active = 1'b0;
  logic move_read = 1'b0;
  logic move_short = 1'b0;
  logic [15:0] move_addr = 16'h0000;
  logic [7:0] move_wdata = 8'h00;
  logic [31:0] latch_lo = 32'hFFFFFFFF;
  logic [31:0] latch_hi = 32'hFFFF5AA5;
  logic [63:0] pin_output_mode_regs = 64'hFFFFFFFFFFFF7FFF;
  // Crossbar drive on the lower group, so that its hand-back can be seen.
  logic [31:0] xbar_out = 32'h3C3C3C3C;
  logic [31:0] xbar_oe = 32'h0F0F0F0F;
  logic [7:0] sfr_rdata, lo_skip_q;
  logic [15:0] mem_addr_q;
  logic [63:0] pin_mode_q;
  logic [31:0] lo_out_q, lo_oe_q, hi_out_q, hi_oe_q;
  logic ext_busy_q;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  emps_top emps_top_i (.sys_clk(sys_clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .move_active(move_active), .move_read(move_read), .move_short(move_short),
    .move_addr(move_addr), .move_wdata(move_wdata), .mem_addr_q(mem_addr_q),
    .latch_lo(latch_lo), .latch_hi(latch_hi), .xbar_out(xbar_out),
    .xbar_oe(xbar_oe), .pin_output_mode_regs(pin_output_mode_regs),
    .pin_mode_q(pin_mode_q), .lo_out_q(lo_out_q), .lo_oe_q(lo_oe_q), .hi_out_q(hi_out_q),
    .hi_oe_q(hi_oe_q), .lo_skip_q(lo_skip_q), .ext_busy_q(ext_busy_q));
  emps_mem_model emps_mem_model_i (.sys_clk(sys_clk), .busy(ext_busy_q), .pin_out(lo_out_q),
    .pin_oe(lo_oe_q));
  // Clock and a ceiling on run length that stops a hang.
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      report_and_stop();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    @(negedge sys_clk);
    chk(sfr_rdata, e);
  endtask : sfr_read
  // Runs one off-chip move and checks ownership during and after it.
  task automatic do_move(input logic rd, input logic sh, input logic [15:0] a,
                         input logic [7:0] wd, input logic [15:0] ea, input logic up);
    int n;
    @(negedge sys_clk);
    move_active = 1'b1;
    move_read = rd;
    move_short = sh;
    move_addr = a;
    move_wdata = wd;
    n = 0;
    while (ext_busy_q !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk(ext_busy_q, 1'b1);
    chk(mem_addr_q, ea);
    chk(pin_mode_q, pin_output_mode_regs);
    if (up) chk({hi_oe_q[7:0], hi_out_q[23:8]}, {rd ? 8'h00 : 8'hFF, ea});
    else chk({lo_oe_q[7:0], lo_out_q[23:8], hi_out_q},
      {rd ? 8'h00 : 8'hFF, ea, latch_hi});
    repeat (2) @(negedge sys_clk);
    move_active = 1'b0;
    n = 0;
    while (ext_busy_q !== 1'b0 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk({ext_busy_q, hi_out_q}, {1'b0, latch_hi});
  endtask : do_move
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    sfr_read(EMPS_PAGE_ADDR, EMPS_PAGE_RST);
    sfr_read(EMPS_CFG_ADDR, EMPS_CFG_RST);
    sfr_read(8'h55, 8'h00);
    chk(lo_skip_q, 8'h00);
    sfr_write(EMPS_CFG_ADDR, 8'hFF);
    sfr_read(EMPS_CFG_ADDR, 8'h3F);
    sfr_write(EMPS_PAGE_ADDR, 8'h5A);
    sfr_read(EMPS_PAGE_ADDR, 8'h5A);
    do_move(1'b1, 1'b1, 16'hC334, 8'h00, 16'h5A34, 1'b1);
    do_move(1'b0, 1'b0, 16'h1234, 8'h3C, 16'h1234, 1'b1);
    sfr_write(EMPS_XBAR_CFG_ADDR, 8'h02);
    sfr_write(EMPS_CFG_ADDR, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk(lo_skip_q, 8'hE0);
    do_move(1'b0, 1'b0, 16'hBEEF, 8'hC3, 16'hBEEF, 1'b0);
    chk({emps_mem_model_i.last_addr_q, emps_mem_model_i.last_data_q}, 24'hBEEFC3);
    // Lower group back on the crossbar; skipped pins 7..5 rest on their latches.
    chk({lo_oe_q, lo_out_q}, 64'h0F0F0FEF_3C3C3CFC);
    sfr_write(EMPS_CFG_ADDR, 8'h10);
    repeat (3) @(negedge sys_clk);
    chk(lo_skip_q, 8'hC0);
    do_move(1'b1, 1'b1, 16'h0077, 8'h00, 16'h5A77, 1'b0);
    // Non-multiplexed: only pins 7 and 6 rest on their latches.
    chk({lo_oe_q, lo_out_q}, 64'h0F0F0FCF_3C3C3CFC);
    report_and_stop();
  end
endmodule : tb_emps_top
